// file: verilog/nv_ctrl_pkg.sv
// constants for the data nonvolatile memory write and read control block
package nv_ctrl_pkg;

  // register map, byte offsets on the special function register port
  localparam logic [7:0] DATA_REG_OFFSET = 8'h08;
  localparam logic [7:0] ADDRESS_REG_OFFSET = 8'h09;
  localparam logic [7:0] CONTROL_REG_OFFSET = 8'h88;
  localparam logic [7:0] UNLOCK_PORT_OFFSET = 8'h89;

  // control register field positions
  localparam int READ_GO_BIT = 0;
  localparam int WRITE_GO_BIT = 1;
  localparam int WRITE_ALLOW_BIT = 2;
  localparam int WRITE_ABORT_BIT = 3;
  localparam int WRITE_DONE_BIT = 4;

  // control register reset values; bit 3 is unknown at power-on, taken as zero here
  localparam logic [7:0] CONTROL_POR_VALUE = 8'h00;

  // unlock pattern written to the unlock port
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;

  // array geometry: 64 bytes at locations 0h to 3fh
  localparam int ARRAY_DEPTH = 64;
  localparam int ARRAY_ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 8;

  // timing: reference clock period and default self-timed write duration
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 4000000;
  localparam int WRITE_TIMER_W = 24;

  // values that read back where nothing is mapped
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // unlock sequence tracker, gray along 55h then aah
  typedef enum logic [1:0] {
    UNLOCK_IDLE = 2'b00,
    UNLOCK_SAW_FIRST = 2'b01,
    UNLOCK_SAW_SECOND = 2'b11
  } unlock_state_e;

endpackage

// file: verilog/nv_write_ctrl.sv
// data nonvolatile memory control: unlock, self-timed byte write, one-cycle read
//
// How it works
// - launch only after 55h, aah, then go
// - each unlock covers at most one byte write
// - write go refused while write allow clear
// - hardware never clears write allow
// - launched write completes despite allow cleared
// - at finish clear go, set done flag
// - done flag cleared only by software
// - control bits 7:5 zero, fixed reset values
// - warm reset during write sets abort flag
// - go bits only settable, hardware clears
// - read go loads data next cycle
// - 64 bytes, byte write replaces location
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps

module nv_write_ctrl #(
  parameter int WRITE_TIME_NS = nv_ctrl_pkg::WRITE_TIME_NS
) (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic srst,
  // warm resets: external reset pin and watchdog, one level each
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  // special function register port
  input wire logic [nv_ctrl_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [nv_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [nv_ctrl_pkg::DATA_W-1:0] reg_rdata,
  // status toward the cpu interrupt logic
  output logic write_done_flag,
  output logic write_active
);

  // least write time rounds up, never under one cycle
  localparam int WRITE_CYCLES_RAW =
    (WRITE_TIME_NS + nv_ctrl_pkg::CLK_PERIOD_NS - 1) / nv_ctrl_pkg::CLK_PERIOD_NS;
  localparam int WRITE_CYCLES = (WRITE_CYCLES_RAW < 1) ? 1 : WRITE_CYCLES_RAW;
  localparam logic [nv_ctrl_pkg::WRITE_TIMER_W-1:0] WRITE_LAST =
    nv_ctrl_pkg::WRITE_TIMER_W'(WRITE_CYCLES - 1);

  // not reset: contents stay unknown until a byte is written there
  logic [nv_ctrl_pkg::DATA_W-1:0] cells [nv_ctrl_pkg::ARRAY_DEPTH];

  logic [nv_ctrl_pkg::DATA_W-1:0] nv_data_q;
  logic [nv_ctrl_pkg::DATA_W-1:0] nv_address_q;
  logic write_allow_q;
  logic write_go_q;
  logic read_go_q;
  logic write_done_q;
  logic write_abort_q;
  nv_ctrl_pkg::unlock_state_e unlock_q;
  nv_ctrl_pkg::unlock_state_e unlock_d;
  logic [nv_ctrl_pkg::WRITE_TIMER_W-1:0] timer_q;
  logic [nv_ctrl_pkg::WRITE_TIMER_W-1:0] timer_d;
  logic [nv_ctrl_pkg::ARRAY_ADDR_W-1:0] pend_addr_q;
  logic [nv_ctrl_pkg::DATA_W-1:0] pend_data_q;
  logic [nv_ctrl_pkg::DATA_W-1:0] rdata_q;

  logic warm_reset;
  logic any_access;
  logic wr_data;
  logic wr_address;
  logic wr_control;
  logic wr_unlock;
  logic launch;
  logic finish;
  logic read_launch;
  logic [nv_ctrl_pkg::DATA_W-1:0] control_view;
  logic rd_data;
  logic rd_address;
  logic rd_control;
  logic go_request;
  logic unlock_ready;

  assign warm_reset = external_reset_pin | watchdog_timer;
  assign any_access = reg_wr | reg_rd;

  // address decode for writes
  always_comb begin
    wr_data = 1'b0;
    wr_address = 1'b0;
    wr_control = 1'b0;
    wr_unlock = 1'b0;
    if (reg_wr && reg_addr == nv_ctrl_pkg::DATA_REG_OFFSET) begin
      wr_data = 1'b1;
    end else if (reg_wr && reg_addr == nv_ctrl_pkg::ADDRESS_REG_OFFSET) begin
      wr_address = 1'b1;
    end else if (reg_wr && reg_addr == nv_ctrl_pkg::CONTROL_REG_OFFSET) begin
      wr_control = 1'b1;
    end else if (reg_wr && reg_addr == nv_ctrl_pkg::UNLOCK_PORT_OFFSET) begin
      wr_unlock = 1'b1;
    end
  end

  // address decode for reads; the unlock port keeps nothing to show
  always_comb begin
    rd_data = 1'b0;
    rd_address = 1'b0;
    rd_control = 1'b0;
    if (reg_rd && reg_addr == nv_ctrl_pkg::DATA_REG_OFFSET) begin
      rd_data = 1'b1;
    end else if (reg_rd && reg_addr == nv_ctrl_pkg::ADDRESS_REG_OFFSET) begin
      rd_address = 1'b1;
    end else if (reg_rd && reg_addr == nv_ctrl_pkg::CONTROL_REG_OFFSET) begin
      rd_control = 1'b1;
    end
  end

  assign go_request = wr_control && reg_wdata[nv_ctrl_pkg::WRITE_GO_BIT];
  assign unlock_ready = unlock_q == nv_ctrl_pkg::UNLOCK_SAW_SECOND;

  // launch needs the full unlock just before, allow set, and no write running
  // allow comes from this same write, so one store may both arm and start
  assign launch = go_request && unlock_ready &&
                  reg_wdata[nv_ctrl_pkg::WRITE_ALLOW_BIT] &&
                  !write_go_q;

  assign finish = write_go_q && timer_q == WRITE_LAST;

  assign read_launch = wr_control && reg_wdata[nv_ctrl_pkg::READ_GO_BIT];

  assign control_view = {3'h0, write_done_q, write_abort_q, write_allow_q,
                         write_go_q, read_go_q};

  // unlock tracker; any access between steps breaks the chain, except a repeated 55h before aah
  always_comb begin
    unlock_d = unlock_q;
    if (write_go_q) begin
      unlock_d = nv_ctrl_pkg::UNLOCK_IDLE;
    end else if (any_access) begin
      case (unlock_q)
        nv_ctrl_pkg::UNLOCK_IDLE: begin
          if (wr_unlock && reg_wdata == nv_ctrl_pkg::UNLOCK_FIRST) begin
            unlock_d = nv_ctrl_pkg::UNLOCK_SAW_FIRST;
          end else begin
            unlock_d = nv_ctrl_pkg::UNLOCK_IDLE;
          end
        end
        nv_ctrl_pkg::UNLOCK_SAW_FIRST: begin
          if (wr_unlock && reg_wdata == nv_ctrl_pkg::UNLOCK_SECOND) begin
            unlock_d = nv_ctrl_pkg::UNLOCK_SAW_SECOND;
          end else if (wr_unlock && reg_wdata == nv_ctrl_pkg::UNLOCK_FIRST) begin
            unlock_d = nv_ctrl_pkg::UNLOCK_SAW_FIRST;
          end else begin
            unlock_d = nv_ctrl_pkg::UNLOCK_IDLE;
          end
        end
        default: begin
          // consumed by the very next access, whatever it is
          unlock_d = nv_ctrl_pkg::UNLOCK_IDLE;
        end
      endcase
    end
  end

  // cycles with no access keep the state: cpu code needs them between steps
  always_ff @(posedge ref_clk) begin
    if (srst || warm_reset) begin
      unlock_q <= nv_ctrl_pkg::UNLOCK_IDLE;
    end else begin
      unlock_q <= unlock_d;
    end
  end

  // write allow: only software or a reset moves it
  always_ff @(posedge ref_clk) begin
    if (srst || warm_reset) begin
      write_allow_q <= nv_ctrl_pkg::CONTROL_POR_VALUE[nv_ctrl_pkg::WRITE_ALLOW_BIT];
    end else if (wr_control) begin
      write_allow_q <= reg_wdata[nv_ctrl_pkg::WRITE_ALLOW_BIT];
    end
  end

  // write go: set by launch only, cleared by the timer; allow is not consulted later
  always_ff @(posedge ref_clk) begin
    if (srst || warm_reset) begin
      write_go_q <= nv_ctrl_pkg::CONTROL_POR_VALUE[nv_ctrl_pkg::WRITE_GO_BIT];
    end else if (launch) begin
      write_go_q <= 1'b1;
    end else if (finish) begin
      write_go_q <= 1'b0;
    end
  end

  // self-timed write counter
  always_comb begin
    timer_d = timer_q + nv_ctrl_pkg::WRITE_TIMER_W'(1);
    if (launch || !write_go_q) begin
      timer_d = '0;
    end
  end

  // held at zero while idle so each write starts from a known count
  always_ff @(posedge ref_clk) begin
    if (srst || warm_reset) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_d;
    end
  end

  // address and data are frozen at launch so software may reuse the registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_addr_q <= '0;
      pend_data_q <= '0;
    end else if (launch) begin
      pend_addr_q <= nv_address_q[nv_ctrl_pkg::ARRAY_ADDR_W-1:0];
      pend_data_q <= nv_data_q;
    end
  end

  // byte replaced whole at the end, which stands for erase then program
  always_ff @(posedge ref_clk) begin
    if (finish && !srst && !warm_reset) begin
      cells[pend_addr_q] <= pend_data_q;
    end
  end

  // done flag: set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst || warm_reset) begin
      write_done_q <= nv_ctrl_pkg::CONTROL_POR_VALUE[nv_ctrl_pkg::WRITE_DONE_BIT];
    end else if (finish) begin
      write_done_q <= 1'b1;
    end else if (wr_control) begin
      write_done_q <= reg_wdata[nv_ctrl_pkg::WRITE_DONE_BIT];
    end
  end

  // abort flag survives warm resets and records a write they cut short
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      write_abort_q <= nv_ctrl_pkg::CONTROL_POR_VALUE[nv_ctrl_pkg::WRITE_ABORT_BIT];
    end else if (warm_reset && write_go_q) begin
      write_abort_q <= 1'b1;
    end else if (warm_reset) begin
      write_abort_q <= write_abort_q;
    end else if (wr_control) begin
      write_abort_q <= reg_wdata[nv_ctrl_pkg::WRITE_ABORT_BIT];
    end
  end

  // read go stands one cycle, then hardware drops it
  always_ff @(posedge ref_clk) begin
    if (srst || warm_reset) begin
      read_go_q <= nv_ctrl_pkg::CONTROL_POR_VALUE[nv_ctrl_pkg::READ_GO_BIT];
    end else if (read_launch) begin
      read_go_q <= 1'b1;
    end else begin
      read_go_q <= 1'b0;
    end
  end

  // data register: a software write in the same cycle beats the array load
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nv_data_q <= '0;
    end else if (wr_data) begin
      nv_data_q <= reg_wdata;
    end else if (read_go_q) begin
      nv_data_q <= cells[nv_address_q[nv_ctrl_pkg::ARRAY_ADDR_W-1:0]];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nv_address_q <= '0;
    end else if (wr_address) begin
      nv_address_q <= reg_wdata;
    end
  end

  // read data one cycle after the strobe; unlock port is write-only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= nv_ctrl_pkg::UNMAPPED_READ;
    end else if (rd_data) begin
      rdata_q <= nv_data_q;
    end else if (rd_address) begin
      rdata_q <= nv_address_q;
    end else if (rd_control) begin
      rdata_q <= control_view;
    end else begin
      // idle cycles show zero so a stale byte is never taken for fresh
      rdata_q <= nv_ctrl_pkg::UNMAPPED_READ;
    end
  end

  assign reg_rdata = rdata_q;
  assign write_done_flag = write_done_q;
  assign write_active = write_go_q;

endmodule

// file: tb/nv_write_ctrl_properties.sv
// port-level properties of the nonvolatile write control
`timescale 1ns/100ps
module nv_write_ctrl_checker #(
  parameter int WRITE_TIME_NS = 250
) (
  // clock and resets
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // status
  input wire logic write_done_flag,
  input wire logic write_active
);
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + 24) / 25;
  logic [15:0] run_q;
  logic warm;
  logic saw_first_q;
  logic armed_q;
  assign warm = external_reset_pin | watchdog_timer;
  // last two accesses were the unlock pair; idle cycles between them are legal
  always_ff @(posedge ref_clk) begin
    if (srst || warm) begin
      saw_first_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (reg_wr || reg_rd) begin
      saw_first_q <= reg_wr && reg_addr == 8'h89 && reg_wdata == 8'h55;
      armed_q <= saw_first_q && reg_wr && reg_addr == 8'h89 && reg_wdata == 8'haa;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= write_active ? run_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_launch;
    $rose(write_active) |-> $past(reg_wr) && $past(reg_addr) == 8'h88 && $past(reg_wdata[1])
      && $past(armed_q);
  endproperty
  a_launch: assert property (p_launch) else $error("write launched without unlock");
  property p_allow;
    $rose(write_active) |-> $past(reg_wdata[2]);
  endproperty
  a_allow: assert property (p_allow) else $error("write launched without allow");
  property p_len;
    $fell(write_active) && !$past(warm) && !$past(srst) |-> run_q == WRITE_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("write length wrong");
  property p_done_set;
    $fell(write_active) && !$past(warm) && !$past(srst) |-> write_done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");
  property p_hold;
    write_active && run_q < WRITE_CYCLES - 1 && !warm |=> write_active;
  endproperty
  a_hold: assert property (p_hold) else $error("write ended early");
  property p_done_keep;
    $fell(write_done_flag) |-> $past(warm) || $past(srst)
      || ($past(reg_wr) && $past(reg_addr) == 8'h88 && !$past(reg_wdata[4]));
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("done flag cleared by hardware");
  property p_ctl_read;
    $past(reg_rd) && $past(reg_addr) == 8'h88 |-> reg_rdata[7:5] == 3'b000
      && reg_rdata[4] == $past(write_done_flag) && reg_rdata[1] == $past(write_active);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");
  property p_abort;
    $past(write_active) && $past(warm) |-> !write_active && !write_done_flag;
  endproperty
  a_abort: assert property (p_abort) else $error("write not cut by reset");
  c_write: cover property ($fell(write_active) && write_done_flag);
  c_abort: cover property ($past(write_active) && $past(warm));
  c_read: cover property ($past(reg_rd) && $past(reg_addr) == 8'h08);
endmodule
bind nv_write_ctrl nv_write_ctrl_checker #(.WRITE_TIME_NS(WRITE_TIME_NS)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .external_reset_pin(external_reset_pin),
  .watchdog_timer(watchdog_timer), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .write_done_flag(write_done_flag), .write_active(write_active));

// file: tb/sfr_master.sv
// cpu side of the special function register port
`timescale 1ns/100ps
module sfr_master (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // strobe left high so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask
endmodule

// file: tb/tb_nv_write_ctrl.sv
// self-checking bench for the nonvolatile write control
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_nv_write_ctrl;
  logic ref_clk, srst, external_reset_pin, watchdog_timer, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  logic write_done_flag, write_active, e_done, e_abort, e_allow;
  int n_fail = 0;
  int n_compared = 0;
  int mem [64];
  int a, d;
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  nv_write_ctrl #(.WRITE_TIME_NS(250)) u_nv_write_ctrl (.ref_clk(ref_clk), .srst(srst),
    .external_reset_pin(external_reset_pin), .watchdog_timer(watchdog_timer),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .write_done_flag(write_done_flag), .write_active(write_active));
  sfr_master u_sfr_master (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic ctl_wr(input logic [7:0] v);
    u_sfr_master.wr(8'h88, v);
    {e_done, e_abort, e_allow} = v[4:2];
  endtask
  task automatic ctl_chk();
    u_sfr_master.rd(8'h88, got);
    `CHK("control", {3'b000, e_done, e_abort, e_allow, 2'b00}, got)
  endtask
  task automatic readback(input int ad);
    u_sfr_master.wr(8'h09, ad[7:0]);
    u_sfr_master.wr(8'h88, {3'b000, e_done, e_abort, e_allow, 2'b01});
    u_sfr_master.idle(1);
    u_sfr_master.rd(8'h08, got);
    `CHK("cell", mem[ad][7:0], got)
  endtask
  // mode 0 proper, 1 no unlock, 2 allow clear, 3 unlock broken by a read
  task automatic attempt(input int m, input int ad, input int dv, input bit fin);
    u_sfr_master.wr(8'h09, ad[7:0]);
    u_sfr_master.wr(8'h08, dv[7:0]);
    if (m != 1) begin
      u_sfr_master.wr(8'h89, 8'h55);
      if (m == 3) u_sfr_master.rd(8'h88, got);
      u_sfr_master.wr(8'h89, 8'haa);
    end
    ctl_wr(m == 2 ? 8'h02 : 8'h06);
    u_sfr_master.idle(2);
    `CHK("write_active", m == 0, write_active)
    if (m == 0 && fin) begin
      if (ad[0]) begin
        ctl_wr(8'h00);
        u_sfr_master.idle(1);
      end
      for (int k = 0; k < 40 && write_done_flag !== 1'b1; k++) @(posedge ref_clk);
      `CHK("done", 1'b1, write_done_flag)
      mem[ad] = dv;
      e_done = 1'b1;
      u_sfr_master.idle(4);
      ctl_chk();
    end
  endtask
  initial begin
    srst = 1'b1;
    external_reset_pin = 1'b0;
    watchdog_timer = 1'b0;
    {e_done, e_abort, e_allow} = 3'b000;
    void'($urandom(32'h29b19a64));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      u_sfr_master.rd(i == 0 ? 8'h88 : (i == 1 ? 8'h89 : (8'h40 | 8'($urandom % 32))), got);
      `CHK("reset_read", 8'h00, got)
    end
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 0 : ((i == 3) ? 63 : $urandom % 64);
      d = $urandom % 256;
      attempt(0, a, d, 1'b1);
      ctl_wr(8'h04);
      readback(a);
    end
    for (int m = 1; m < 4; m++) begin
      attempt(m, a, d ^ 255, 1'b0);
      u_sfr_master.idle(12);
      readback(a);
    end
    for (int r = 0; r < 2; r++) begin
      attempt(0, a, d ^ 90, 1'b0);
      u_sfr_master.idle(1 + $urandom % 5);
      if (r == 0) external_reset_pin <= 1'b1;
      else watchdog_timer <= 1'b1;
      @(posedge ref_clk);
      external_reset_pin <= 1'b0;
      watchdog_timer <= 1'b0;
      u_sfr_master.idle(1);
      {e_done, e_abort, e_allow} = 3'b010;
      `CHK("write_active", 1'b0, write_active)
      ctl_chk();
      readback(a);
      ctl_wr(8'h00);
    end
    final_report();
  end
  // the sequence needs well under 2000 cycles
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
endmodule
